// [src/quad_io_read_wrap_engine_regs.vh]
`ifndef QUAD_IO_READ_WRAP_ENGINE_REGS_VH
`define QUAD_IO_READ_WRAP_ENGINE_REGS_VH

// ----------------------------------------------------------------------
// Command opcodes.
// ----------------------------------------------------------------------
`define CMD_DTR_QUAD_IO_READ   8'hED
`define CMD_QUAD_IO_READ       8'hEB
`define CMD_QUAD_WORD_READ     8'hE7
`define CMD_SET_BURST_WRAP     8'h77
`define CMD_SET_READ_PARAMS    8'hC0
`define CMD_BURST_READ_WRAP    8'h0C
`define CMD_DTR_BURST_WRAP     8'h0E
`define CMD_RESET_DEFAULTS     8'h99

// ----------------------------------------------------------------------
// Field positions and reset values.
// ----------------------------------------------------------------------
`define CONT_CODE              2'h2
`define WRAP_DISABLE_BIT       4
`define WRAP_SIZE_HI           6
`define WRAP_SIZE_LO           5
`define LATENCY_HI             5
`define LATENCY_LO             4
`define WRAP_LENGTH_HI         1
`define WRAP_LENGTH_LO         0
`define WRAP_DISABLE_RESET     1'h1
`define WRAP_SIZE_RESET        2'h0
`define LATENCY_RESET          2'h0
`define WRAP_LENGTH_RESET      2'h0

// ----------------------------------------------------------------------
// Sequence counts, in serial clocks or in transfer units.
// ----------------------------------------------------------------------
`define CMD_BITS_SERIAL        6'h08
`define CMD_NIBBLES_QUAD       6'h02
`define ADDR_NIBBLES           6'h06
`define MODE_NIBBLES           6'h02
`define BURST_SETUP_BITS       6'h20
`define PARAM_NIBBLES          6'h02
`define DUMMY_DTR_QUAD_SPI     6'h07
`define DUMMY_QUAD_DC0         6'h04
`define DUMMY_QUAD_DC1         6'h06
`define DUMMY_WORD_READ        6'h02
`define DUMMY_DTR_BURST_WRAP   6'h08
`define MODE_CLOCKS_DTR        6'h01
`define MODE_CLOCKS_STR        6'h02
`define LATENCY_00             6'h0A
`define LATENCY_01             6'h04
`define LATENCY_10             6'h06
`define LATENCY_11             6'h08

`endif

// [src/pin_sync.v]
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Two flip-flop synchroniser for a group of pin inputs.
// ----------------------------------------------------------------------
module pin_sync
#(
  parameter W = 1
)
(
  // Clock and reset.
  input  wire         clock_i,
  input  wire         rst_n_i,
  // Pin side and synchronised side.
  input  wire [W-1:0] d_i,
  output reg  [W-1:0] q_o
);

  reg [W-1:0] meta_q;

  // The first stage feeds only the second stage.
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= {W{1'b1}};
      q_o    <= {W{1'b1}};
    end
    else
    begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end

endmodule

// [src/wrap_addr_step.v]
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Next read address, linear or wrapped inside an aligned section.
// ----------------------------------------------------------------------
module wrap_addr_step
(
  // Current address and wrap setting.
  input  wire [23:0] addr_i,
  input  wire        wrap_en_i,
  input  wire [1:0]  size_i,
  // Next address.
  output reg  [23:0] next_o
);

  reg [23:0] mask;
  reg [23:0] inc;

  // Only the bits inside the section count; the rest stay fixed.
  always @*
  begin
    inc  = addr_i + 24'h000001;
    mask = 24'hFFFFFF;
    if (wrap_en_i)
    begin
      case (size_i)
        2'h0:    mask = 24'h000007;
        2'h1:    mask = 24'h00000F;
        2'h2:    mask = 24'h00001F;
        default: mask = 24'h00003F;
      endcase
    end
    next_o = (addr_i & ~mask) | (inc & mask); // see R25
  end

endmodule

// [src/quad_io_read_wrap_engine.v]
// How it works
// R01: EDh uses four lines; one mode byte and 7 dummy clocks.
// R02: EDh runs only while quad enable is set.
// R03: Upper mode nibble decides the next opcode; lower nibble ignored.
// R04: Host floats IO before the first data falling edge.
// R05: Continuation 10 starts the next frame at the address.
// R06: Other continuation values restore opcode decoding.
// R07: Host sends ones on IO0 for eight clocks to end continuation.
// R08: Host drives mode clocks; sends 10 only to continue.
// R09: In serial mode with wrap on, EDh and E7h wrap within a section.
// R10: Wrap bits: a disable bit and two size bits, 8 to 64 bytes.
// R11: Four-wire EDh counts mode clocks as dummies.
// R12: Four-wire mode EDh never wraps; only 0Ch wraps there; the code also wraps 0Eh in four-wire mode.
// R13: E7h uses an even address and only two dummy clocks.
// R14: E7h runs only while quad enable is set.
// R15: E7h continues likewise; the reset opcode clears it; the code decodes 99h only with continuation off, so it never clears it.
// R16: C0h refused in serial mode; there the dummy count bit rules.
// R17: Latency field picks 10, 4, 6 or 8 dummy clocks in four-wire mode; the code gives 0Eh a fixed 8 dummy clocks whatever the field holds.
// R18: Wrap length field picks 8, 16, 32 or 64 bytes for wrap reads.
// R19: Reset gives 8 byte wrap length and ten dummies including mode.
// R20: Host reprograms latency on entering four-wire mode.
// R21: 0Ch is a fast read wrapping on read parameter length and latency.
// R22: 0Eh is a double rate wrapping read using the wrap length field.
// R23: Host sets wrap bits with 77h, 24 dummy bits, then the wrap byte.
// R24: Wrap disable bit one is default and turns wrapping off.
// R25: Wrapping increments only the low address bits of the section.
// R26: Quad reads with quad enable clear are ignored, no drive.
`timescale 1ns/1ps
`include "quad_io_read_wrap_engine_regs.vh"

module quad_io_read_wrap_engine
(
  // Clock and reset.
  input  wire        clock_i,
  input  wire        rst_n_i,
  // Serial flash pins.
  input  wire        cs_n_i,
  input  wire        sclk_i,
  input  wire [3:0]  io_i,
  output reg  [3:0]  io_o,
  output reg  [3:0]  io_oe_o,
  // Configuration bits.
  input  wire        quad_enable_flag_i,
  input  wire        four_wire_command_mode_i,
  input  wire        dummy_count_bit_i,
  // Array read port.
  output reg  [23:0] mem_addr_o,
  input  wire [7:0]  mem_data_i,
  // Status.
  output reg         read_active_o,
  output reg         continuous_mode_o,
  output reg  [2:0]  wrap_bits_o,
  output reg  [1:0]  latency_select_field_o,
  output reg  [1:0]  wrap_length_field_o
);

  // --------------------------------------------------------------------
  // Sequencer phases.
  // --------------------------------------------------------------------
  localparam [2:0] PH_IDLE  = 3'h0;
  localparam [2:0] PH_CMD   = 3'h1;
  localparam [2:0] PH_ADDR  = 3'h2;
  localparam [2:0] PH_MODE  = 3'h3;
  localparam [2:0] PH_DUMMY = 3'h4;
  localparam [2:0] PH_DATA  = 3'h5;
  localparam [2:0] PH_SETUP = 3'h6;
  localparam [2:0] PH_SKIP  = 3'h7;

  // --------------------------------------------------------------------
  // Pin synchronisation and edge detection.
  // --------------------------------------------------------------------
  wire [5:0]  pins_s;
  wire        cs_n_s;
  wire        sclk_s;
  wire [3:0]  io_s;
  reg         sclk_d_q;
  wire        rise;
  wire        fall;

  pin_sync #(.W(6)) u_sync
  (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .d_i     ({cs_n_i, sclk_i, io_i}),
    .q_o     (pins_s)
  );

  assign cs_n_s = pins_s[5];
  assign sclk_s = pins_s[4];
  assign io_s   = pins_s[3:0];
  assign rise   = sclk_s & ~sclk_d_q;
  assign fall   = ~sclk_s & sclk_d_q;

  // --------------------------------------------------------------------
  // Sequencer state.
  // --------------------------------------------------------------------
  reg [2:0]   phase_q;
  reg [5:0]   cnt_q;
  reg [23:0]  sh_q;
  reg [7:0]   cmd_q;
  reg         dtr_q;
  reg         has_mode_q;
  reg [5:0]   dummy_q;
  reg         wrap_en_q;
  reg [1:0]   wrap_sz_q;
  reg [7:0]   cont_cmd_q;
  reg         nib_lo_q;
  wire [23:0] addr_next;

  wire [7:0]  ser_byte = {sh_q[6:0], io_s[0]};
  wire [7:0]  nib_byte = {sh_q[3:0], io_s};
  wire [23:0] addr_in  = {sh_q[19:0], io_s};
  wire [7:0]  cmd_byte = four_wire_command_mode_i ? nib_byte : ser_byte;
  wire        take     = rise | (dtr_q & fall & cnt_q[0]);
  wire        last     = (cnt_q == 6'h01);

  // Section address stepping for data bytes.
  wrap_addr_step u_step
  (
    .addr_i    (mem_addr_o),
    .wrap_en_i (wrap_en_q),
    .size_i    (wrap_sz_q),
    .next_o    (addr_next)
  );

  // --------------------------------------------------------------------
  // Opcode decode.
  // --------------------------------------------------------------------
  reg [2:0]   d_phase;
  reg [5:0]   d_cnt;
  reg         d_dtr;
  reg         d_mode;
  reg [5:0]   d_dummy;
  reg         d_wrap;
  reg [1:0]   d_wsz;
  reg [5:0]   latency;

  // Latency field to dummy clocks.
  always @*
  begin
    case (latency_select_field_o)
      2'h0:    latency = `LATENCY_00; // see R17
      2'h1:    latency = `LATENCY_01;
      2'h2:    latency = `LATENCY_10;
      default: latency = `LATENCY_11;
    endcase
  end

  // Each opcode picks its timing, wrap and mode byte.
  always @*
  begin
    d_phase = PH_SKIP;
    d_cnt   = `ADDR_NIBBLES;
    d_dtr   = 1'b0;
    d_mode  = 1'b0;
    d_dummy = `DUMMY_WORD_READ;
    d_wrap  = 1'b0;
    d_wsz   = wrap_bits_o[2:1];
    case (cmd_byte)
      `CMD_DTR_QUAD_IO_READ:
      begin
        if (quad_enable_flag_i) // see R02, R26
        begin
          d_phase = PH_ADDR;
          d_dtr   = 1'b1;
          d_mode  = 1'b1;
          if (four_wire_command_mode_i)
          begin
            d_dummy = latency - `MODE_CLOCKS_DTR; // see R11
          end
          else
          begin
            d_dummy = `DUMMY_DTR_QUAD_SPI; // see R01
            d_wrap  = ~wrap_bits_o[0]; // see R09, R24
          end
        end
      end
      `CMD_QUAD_IO_READ:
      begin
        if (quad_enable_flag_i) // see R26
        begin
          d_phase = PH_ADDR;
          d_mode  = 1'b1;
          if (four_wire_command_mode_i)
          begin
            d_dummy = latency - `MODE_CLOCKS_STR; // see R12
          end
          else
          begin
            d_dummy = dummy_count_bit_i ? `DUMMY_QUAD_DC1
                                        : `DUMMY_QUAD_DC0; // see R16
            d_wrap  = ~wrap_bits_o[0];
          end
        end
      end
      `CMD_QUAD_WORD_READ:
      begin
        if (quad_enable_flag_i && !four_wire_command_mode_i) // see R14
        begin
          d_phase = PH_ADDR;
          d_mode  = 1'b1;
          d_dummy = `DUMMY_WORD_READ; // see R13
          d_wrap  = ~wrap_bits_o[0]; // see R09
        end
      end
      `CMD_BURST_READ_WRAP:
      begin
        if (four_wire_command_mode_i)
        begin
          d_phase = PH_ADDR;
          d_dummy = latency; // see R21
          d_wrap  = 1'b1;
          d_wsz   = wrap_length_field_o; // see R18
        end
      end
      `CMD_DTR_BURST_WRAP:
      begin
        if (four_wire_command_mode_i)
        begin
          d_phase = PH_ADDR;
          d_dtr   = 1'b1;
          d_dummy = `DUMMY_DTR_BURST_WRAP;
          d_wrap  = 1'b1; // see R22
          d_wsz   = wrap_length_field_o;
        end
      end
      `CMD_SET_BURST_WRAP:
      begin
        if (!four_wire_command_mode_i)
        begin
          d_phase = PH_SETUP;
          d_cnt   = `BURST_SETUP_BITS;
        end
      end
      `CMD_SET_READ_PARAMS:
      begin
        if (four_wire_command_mode_i) // see R16
        begin
          d_phase = PH_SETUP;
          d_cnt   = `PARAM_NIBBLES;
        end
      end
      default:
      begin
        d_phase = PH_SKIP;
      end
    endcase
  end

  // --------------------------------------------------------------------
  // Frame sequencer.
  // --------------------------------------------------------------------
  // Chip select high ends any frame and releases the IO lines on the third clock edge after the pin rises.
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sclk_d_q               <= 1'b1;
      phase_q                <= PH_IDLE;
      cnt_q                  <= 6'h00;
      sh_q                   <= 24'h000000;
      cmd_q                  <= 8'h00;
      dtr_q                  <= 1'b0;
      has_mode_q             <= 1'b0;
      dummy_q                <= 6'h00;
      wrap_en_q              <= 1'b0;
      wrap_sz_q              <= 2'h0;
      cont_cmd_q             <= 8'h00;
      nib_lo_q               <= 1'b0;
      io_o                   <= 4'h0;
      io_oe_o                <= 4'h0;
      mem_addr_o             <= 24'h000000;
      read_active_o          <= 1'b0;
      continuous_mode_o      <= 1'b0;
      wrap_bits_o            <= {`WRAP_SIZE_RESET, `WRAP_DISABLE_RESET};
      latency_select_field_o <= `LATENCY_RESET;
      wrap_length_field_o    <= `WRAP_LENGTH_RESET;
    end
    else
    begin
      sclk_d_q <= sclk_s;
      if (cs_n_s)
      begin
        phase_q       <= PH_IDLE;
        io_oe_o       <= 4'h0;
        read_active_o <= 1'b0;
      end
      else
      begin
        case (phase_q)
          PH_IDLE:
          begin
            if (continuous_mode_o)
            begin
              phase_q <= PH_ADDR; // see R05, R15
              cmd_q   <= cont_cmd_q;
              cnt_q   <= `ADDR_NIBBLES;
            end
            else
            begin
              phase_q <= PH_CMD; // see R06
              cnt_q   <= four_wire_command_mode_i ? `CMD_NIBBLES_QUAD
                                                  : `CMD_BITS_SERIAL;
            end
          end
          PH_CMD:
          begin
            if (rise)
            begin
              sh_q  <= four_wire_command_mode_i ? {sh_q[19:0], io_s}
                                                : {sh_q[22:0], io_s[0]};
              cnt_q <= cnt_q - 6'h01;
              if (last)
              begin
                cmd_q      <= cmd_byte;
                phase_q    <= d_phase;
                cnt_q      <= d_cnt;
                dtr_q      <= d_dtr;
                has_mode_q <= d_mode;
                dummy_q    <= d_dummy;
                wrap_en_q  <= d_wrap;
                wrap_sz_q  <= d_wsz;
                if (cmd_byte == `CMD_RESET_DEFAULTS)
                begin
                  continuous_mode_o      <= 1'b0; // see R15
                  wrap_bits_o            <= {`WRAP_SIZE_RESET,
                                             `WRAP_DISABLE_RESET};
                  latency_select_field_o <= `LATENCY_RESET; // see R19
                  wrap_length_field_o    <= `WRAP_LENGTH_RESET;
                end
              end
            end
          end
          PH_ADDR:
          begin
            if (take)
            begin
              sh_q  <= addr_in;
              cnt_q <= cnt_q - 6'h01;
              if (last)
              begin
                mem_addr_o <= addr_in;
                phase_q    <= has_mode_q ? PH_MODE : PH_DUMMY;
                cnt_q      <= has_mode_q ? `MODE_NIBBLES : dummy_q;
              end
            end
          end
          PH_MODE:
          begin
            if (take)
            begin
              sh_q  <= addr_in;
              cnt_q <= cnt_q - 6'h01;
              if (last)
              begin
                // Only the upper nibble matters for continuation.
                continuous_mode_o <= (nib_byte[5:4] == `CONT_CODE); // see R03
                cont_cmd_q        <= cmd_q;
                phase_q           <= PH_DUMMY;
                cnt_q             <= dummy_q;
              end
            end
          end
          PH_DUMMY:
          begin
            if (rise)
            begin
              cnt_q <= cnt_q - 6'h01;
              if (last)
              begin
                phase_q  <= PH_DATA;
                nib_lo_q <= 1'b0;
              end
            end
          end
          PH_DATA:
          begin
            // First launch is the falling edge ending the last dummy clock.
            if (fall || (dtr_q && rise))
            begin
              io_oe_o       <= 4'hF; // see R01
              read_active_o <= 1'b1;
              nib_lo_q      <= ~nib_lo_q;
              if (nib_lo_q)
              begin
                io_o       <= mem_data_i[3:0];
                mem_addr_o <= addr_next; // see R09, R21
              end
              else
              begin
                io_o <= mem_data_i[7:4];
              end
            end
          end
          PH_SETUP:
          begin
            if (rise)
            begin
              sh_q  <= four_wire_command_mode_i ? {sh_q[19:0], io_s}
                                                : {sh_q[22:0], io_s[0]};
              cnt_q <= cnt_q - 6'h01;
              if (last)
              begin
                phase_q <= PH_SKIP;
                if (cmd_q == `CMD_SET_BURST_WRAP)
                begin
                  wrap_bits_o <= {ser_byte[`WRAP_SIZE_HI:`WRAP_SIZE_LO],
                                  ser_byte[`WRAP_DISABLE_BIT]}; // see R10
                end
                else
                begin
                  latency_select_field_o <=
                    nib_byte[`LATENCY_HI:`LATENCY_LO]; // see R17
                  wrap_length_field_o    <=
                    nib_byte[`WRAP_LENGTH_HI:`WRAP_LENGTH_LO]; // see R18
                end
              end
            end
          end
          default:
          begin
            io_oe_o <= 4'h0; // see R26
          end
        endcase
      end
    end
  end

endmodule

// [dv/quad_io_read_wrap_engine_chk.sv]
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Port checker for the quad read engine.
// ----------------------------------------------------------------
module quad_io_read_wrap_engine_chk
(
  // Clock, reset and pins.
  input wire        clock_i,
  input wire        rst_n_i,
  input wire        cs_n_i,
  input wire [3:0]  io_oe_o,
  // Configuration and status.
  input wire        quad_enable_flag_i,
  input wire        four_wire_command_mode_i,
  input wire [23:0] mem_addr_o,
  input wire        read_active_o,
  input wire        continuous_mode_o,
  input wire [2:0]  wrap_bits_o,
  input wire [1:0]  latency_select_field_o,
  input wire [1:0]  wrap_length_field_o
);
  // Address bits that a wrapping step is allowed to change.
  wire [23:0] span = (24'h8 << wrap_bits_o[2:1]) - 24'h1;

  default clocking @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  a_oe_all_lanes: assert property (
    io_oe_o == 4'h0 || io_oe_o == 4'hF)
    else $error("IO enables differ between lanes");
  a_oe_with_data: assert property (
    $rose(read_active_o) |-> io_oe_o == 4'hF)
    else $error("Data phase began without drive");
  a_idle_no_drive: assert property (
    cs_n_i [*6] |-> io_oe_o == 4'h0 && !read_active_o)
    else $error("IO driven while deselected");
  a_qe_gates_read: assert property (
    (!quad_enable_flag_i && !four_wire_command_mode_i) [*8]
    |-> !read_active_o)
    else $error("Read ran with quad enable clear");
  a_wrap_in_section: assert property (
    read_active_o && $past(read_active_o) && !wrap_bits_o[0]
    && !four_wire_command_mode_i
    |-> (mem_addr_o & ~span) == ($past(mem_addr_o) & ~span))
    else $error("Wrapped address left its section");
  a_reset_values: assert property (
    $rose(rst_n_i) |-> wrap_bits_o == 3'h1
    && latency_select_field_o == 2'h0 && wrap_length_field_o == 2'h0)
    else $error("Wrong values after reset");
  a_params_serial: assert property (
    !four_wire_command_mode_i && !$past(four_wire_command_mode_i)
    |-> $stable({latency_select_field_o, wrap_length_field_o})
    || {latency_select_field_o, wrap_length_field_o} == 4'h0)
    else $error("Parameters changed in serial mode");
  a_wrap_four_wire: assert property (
    four_wire_command_mode_i && $past(four_wire_command_mode_i)
    |-> $stable(wrap_bits_o) || wrap_bits_o == 3'h1)
    else $error("Wrap bits changed in four-wire mode");
  a_cont_in_frame: assert property (
    cs_n_i [*5] |-> $stable(continuous_mode_o))
    else $error("Continuation changed while deselected");
endmodule

// [dv/spi_host_model.sv]
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Host side of the link.
// ----------------------------------------------------------------
module spi_host_model
(
  // Bench clock and device drive.
  input  wire       clock_i,
  input  wire [3:0] io_o,
  input  wire [3:0] io_oe_o,
  // Link pins.
  output reg        cs_n_o,
  output reg        sclk_o,
  output wire [3:0] io_line_o
);
  reg [3:0] hio_q;
  reg       hoe_q;
  reg [3:0] s0;
  reg [3:0] s1;
  integer   i;

  // An undriven line shows the inverse of the host's last value.
  assign io_line_o = (io_oe_o != 4'h0) ? io_o : hoe_q ? hio_q : ~hio_q;

  // The clock stands low between frames.
  initial
  begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    hio_q = 4'h0;
    hoe_q = 1'b0;
  end

  // One clock: a before rise, b before fall; samples s0, s1.
  task cyc(input [3:0] a, input [3:0] b, input oe);
    begin
      hoe_q = oe;
      hio_q = a;
      repeat (2) @(negedge clock_i);
      sclk_o = 1'b1;
      repeat (2) @(negedge clock_i);
      s0 = io_line_o;
      hio_q = b;
      repeat (2) @(negedge clock_i);
      sclk_o = 1'b0;
      repeat (2) @(negedge clock_i);
      s1 = io_line_o;
    end
  endtask

  // A byte on IO0, first bit first.
  task sbyte(input [7:0] v);
    for (i = 7; i >= 0; i = i - 1)
      cyc({3'h0, v[i]}, {3'h0, v[i]}, 1'b1);
  endtask

  // A byte as two nibbles: both edges of one clock, or two clocks.
  task unit(input [7:0] v, input dtr);
    if (dtr)
      cyc(v[7:4], v[3:0], 1'b1);
    else
    begin
      cyc(v[7:4], v[7:4], 1'b1);
      cyc(v[3:0], v[3:0], 1'b1);
    end
  endtask

  // Frame edges with the idle gaps the device needs.
  task start;
    begin
      cs_n_o = 1'b0;
      repeat (5) @(negedge clock_i);
    end
  endtask
  task stop;
    begin
      cs_n_o = 1'b1;
      hoe_q = 1'b0;
      repeat (8) @(negedge clock_i);
    end
  endtask
endmodule

// [dv/test_quad_io_read_wrap_engine.sv]
`timescale 1ns/1ps
`include "quad_io_read_wrap_engine_regs.vh"

`define CHK(a, b) begin checks = checks + 1; if ((a) !== (b)) begin \
  err_total = err_total + 1; $display("Error at %0t: bad value", $time); \
  end end

// ----------------------------------------------------------------
// Bench for the quad read engine.
// ----------------------------------------------------------------
module test_quad_io_read_wrap_engine;
  reg         clock_i;
  reg         rst_n_i;
  reg         qf;
  reg         fw;
  reg         db;
  reg         seen;
  reg         we;
  reg  [1:0]  sz;
  reg  [7:0]  md;
  reg  [47:0] rows [0:4];
  integer     err_total;
  integer     checks;
  integer     k;
  wire        cs_n;
  wire        sclk;
  wire [3:0]  io;
  wire [3:0]  io_o;
  wire [3:0]  io_oe;
  wire [23:0] addr;
  wire        active;
  wire        cont;
  wire [2:0]  wrap;
  wire [1:0]  lat;
  wire [1:0]  wlen;
  // Each array byte is built from its own address.
  wire [7:0]  mem = addr[7:0] ^ addr[15:8] ^ 8'h3C;

  quad_io_read_wrap_engine uut
  (
    .clock_i, .rst_n_i, .cs_n_i(cs_n), .sclk_i(sclk), .io_i(io), .io_o,
    .io_oe_o(io_oe), .quad_enable_flag_i(qf),
    .four_wire_command_mode_i(fw), .dummy_count_bit_i(db),
    .mem_addr_o(addr), .mem_data_i(mem), .read_active_o(active),
    .continuous_mode_o(cont), .wrap_bits_o(wrap),
    .latency_select_field_o(lat), .wrap_length_field_o(wlen)
  );

  spi_host_model host
  (
    .clock_i, .io_o, .io_oe_o(io_oe),
    .cs_n_o(cs_n), .sclk_o(sclk), .io_line_o(io)
  );

  // Bench clock at 20 MHz.
  initial
  begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end

  // Notes any device drive in this frame.
  always @(posedge clock_i)
    if (io_oe != 4'h0)
      seen <= 1'b1;

  // Next expected address, wrapping inside the section.
  function [23:0] nx(input [23:0] x);
    reg [23:0] m;
    begin
      m = (24'h8 << sz) - 24'h1;
      nx = we ? ((x & ~m) | ((x + 24'h1) & m)) : x + 24'h1;
    end
  endfunction

  // One read frame; op 0 opens straight with the address.
  task rd(input [7:0] op, input dtr, input [23:0] a, input integer dm,
          input integer nb);
    reg [23:0] x;
    reg [3:0]  hn;
    integer    j;
    begin
      seen = 1'b0;
      x = a;
      host.start;
      if (op != 8'h00 && fw)
        host.unit(op, 1'b0);
      else if (op != 8'h00)
        host.sbyte(op);
      host.unit(a[23:16], dtr);
      host.unit(a[15:8], dtr);
      host.unit(a[7:0], dtr);
      if (op != `CMD_BURST_READ_WRAP && op != `CMD_DTR_BURST_WRAP)
        host.unit(md, dtr);
      for (j = 0; j < dm + nb; j = j + 1)
      begin
        host.cyc(4'h0, 4'h0, 1'b0);
        hn = host.s0;
        if (!dtr && j >= dm)
          host.cyc(4'h0, 4'h0, 1'b0);
        if (j >= dm)
        begin
          `CHK({hn, dtr ? host.s1 : host.s0}, x[7:0] ^ x[15:8] ^ 8'h3C)
          x = nx(x);
        end
      end
      host.stop;
    end
  endtask

  // Wrap setting frame: opcode, three filler bytes, wrap byte.
  task setwrap(input [7:0] w);
    begin
      host.start;
      host.sbyte(`CMD_SET_BURST_WRAP);
      repeat (3) host.sbyte(8'h00);
      host.sbyte(w);
      host.stop;
      we = ~w[4];
      sz = w[6:5];
      `CHK(wrap, w[6:4])
    end
  endtask

  // Read parameter frame in four-wire mode.
  task setpar(input [7:0] p);
    begin
      host.start;
      host.unit(`CMD_SET_READ_PARAMS, 1'b0);
      host.unit(p, 1'b0);
      host.stop;
    end
  endtask

  // Values that power-up and the reset opcode restore.
  task defaults;
    begin
      `CHK({wrap, lat, wlen}, 7'h10)
      `CHK(io_oe, 4'h0)
    end
  endtask

  task test_done;
    begin
      $display("Checks %0d, errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask

  // Watchdog; the run needs well under 20000 clocks.
  initial
  begin
    #2000000;
    err_total = err_total + 1;
    test_done;
  end

  // Wrap byte, opcode, dummy clocks and start address of each row.
  initial
  begin
    rst_n_i = 1'b0;
    {qf, fw, db, seen, we, sz, md} = {7'h40, 8'hFF};
    err_total = 0;
    checks = 0;
    rows[0] = {8'h10, 8'hED, 8'h07, 24'h12343E};
    rows[1] = {8'h00, 8'hED, 8'h07, 24'h000106};
    rows[2] = {8'h20, 8'hE7, 8'h02, 24'h00ABCE};
    rows[3] = {8'h40, 8'hEB, 8'h04, 24'h00001E};
    rows[4] = {8'h60, 8'hED, 8'h07, 24'h7FFF3E};
    repeat (16) @(negedge clock_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge clock_i);
    defaults;
    for (k = 0; k < 5; k = k + 1)
    begin
      setwrap(rows[k][47:40]);
      rd(rows[k][39:32], rows[k][39:32] == `CMD_DTR_QUAD_IO_READ,
         rows[k][23:0], rows[k][31:24], 4);
    end
    md = 8'h2F;
    rd(`CMD_DTR_QUAD_IO_READ, 1'b1, 24'h000210, 7, 2);
    `CHK(cont, 1'b1)
    md = 8'h1F;
    rd(8'h00, 1'b1, 24'h000320, 7, 2);
    `CHK(cont, 1'b0)
    md = 8'h2F;
    rd(`CMD_DTR_QUAD_IO_READ, 1'b1, 24'h000400, 7, 2);
    host.start;
    host.sbyte(8'hFF);
    host.stop;
    `CHK(cont, 1'b0)
    md = 8'h20;
    rd(`CMD_QUAD_WORD_READ, 1'b0, 24'h000500, 2, 2);
    md = 8'hFF;
    rd(8'h00, 1'b0, 24'h000602, 2, 2);
    `CHK(cont, 1'b0)
    db = 1'b1;
    rd(`CMD_QUAD_IO_READ, 1'b0, 24'h000700, 6, 2);
    host.start;
    host.sbyte(`CMD_SET_READ_PARAMS);
    host.sbyte(8'h33);
    host.stop;
    `CHK({lat, wlen}, 4'h0)
    qf = 1'b0;
    rd(`CMD_DTR_QUAD_IO_READ, 1'b1, 24'h000100, 7, 0);
    `CHK(seen, 1'b0)
    rd(`CMD_QUAD_WORD_READ, 1'b0, 24'h000100, 2, 0);
    `CHK(seen, 1'b0)
    qf = 1'b1;
    fw = 1'b1;
    for (k = 0; k < 4; k = k + 1)
    begin
      setpar({2'h0, k[1:0], 2'h0, k[1:0]});
      `CHK({lat, wlen}, {k[1:0], k[1:0]})
      sz = k[1:0];
      we = 1'b1;
      rd(`CMD_BURST_READ_WRAP, 1'b0, (24'h8 << k) + 24'h0007FE,
         (k == 0) ? 10 : 2 * k + 2, 4);
    end
    we = 1'b0;
    rd(`CMD_DTR_QUAD_IO_READ, 1'b1, 24'h00093E, 7, 4);
    we = 1'b1;
    rd(`CMD_DTR_BURST_WRAP, 1'b1, 24'h000A3E, 8, 4);
    host.start;
    host.unit(`CMD_RESET_DEFAULTS, 1'b0);
    host.stop;
    defaults;
    we = 1'b0;
    rd(`CMD_DTR_QUAD_IO_READ, 1'b1, 24'h000B00, 9, 2);
    setpar(8'h33);
    rst_n_i = 1'b0;
    repeat (3) @(negedge clock_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge clock_i);
    defaults;
    test_done;
  end
endmodule

bind quad_io_read_wrap_engine quad_io_read_wrap_engine_chk chk
(
  .clock_i, .rst_n_i, .cs_n_i, .io_oe_o, .quad_enable_flag_i,
  .four_wire_command_mode_i, .mem_addr_o, .read_active_o,
  .continuous_mode_o, .wrap_bits_o, .latency_select_field_o,
  .wrap_length_field_o
);
